/* File: design/pfs_pkg.sv */
// Shared constants and carrier types for the PWM frequency synthesizer
package pfs_pkg;

    // Hardware resolution variants, each with its own reference clock
    typedef enum logic {PFS_RES_ONE, PFS_RES_TWO} pfs_res_type;

    // Clock and reference figures
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned REF_ONE_HZ      = 60000;
    localparam int unsigned REF_TWO_HZ      = 80000;
    localparam int unsigned FREQ_MIN_HZ     = 10;
    localparam int unsigned FREQ_MAX_FAST   = 20000;
    localparam int unsigned FREQ_MAX_SLOW   = 50;
    localparam int unsigned DUTY_FULL       = 1000;
    localparam int unsigned PIPE_LATENCY    = 4;

    // Reference tick periods in mclk cycles, rounded to nearest
    localparam int unsigned REF_ONE_CYC = (CLK_HZ + REF_ONE_HZ / 2) / REF_ONE_HZ;
    localparam int unsigned REF_TWO_CYC = (CLK_HZ + REF_TWO_HZ / 2) / REF_TWO_HZ;

    // Reset values
    localparam logic [15:0] FREQ_RESET  = 16'h0000;
    localparam logic [9:0]  DUTY_RESET  = 10'h1f4;

    // Request carrier from firmware
    typedef struct packed {
        logic        freqValid;
        logic [15:0] freqHz;
        logic        dutyValid;
        logic [9:0]  dutyPermil;
        logic        modeValid;
        logic        modeOn;
    } pfs_req_type;

    // Divider settings handed to the period generator
    typedef struct packed {
        logic        enable;
        logic [13:0] scalar;
        logic [13:0] highTicks;
    } pfs_cfg_type;

endpackage : pfs_pkg

/* File: design/pfs_period_gen.sv */
// Reference-tick period counter that drives the output pair, or the standard output when the fast option is not fitted
`timescale 1ns/1ps
module pfs_period_gen
    import pfs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire logic        refTick,
    input  wire pfs_cfg_type cfg,
    output logic             periodEnd,
    output logic             pwmLevel
);

    typedef struct packed {
        logic [13:0] count;
        pfs_cfg_type live;
        logic        level;
        logic        wrap;
    } pfs_pg_state_type;

    pfs_pg_state_type state_q, state_d;

    // Period runs scalar reference ticks; settings latch on a wrap, or at once when live is off and cfg.enable is set
    always_comb begin
        state_d      = state_q;
        state_d.wrap = 1'b0;
        if (refTick) begin
            if (state_q.count + 14'h0001 >= state_q.live.scalar) begin
                state_d.count = 14'h0000;
                state_d.live  = cfg;
                state_d.wrap  = 1'b1;
            end else begin
                state_d.count = state_q.count + 14'h0001;
            end
            state_d.level = state_d.live.enable && (state_d.count < state_d.live.highTicks);
        end
        if (!state_q.live.enable && cfg.enable) begin
            state_d.live  = cfg;
            state_d.count = 14'h0000;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= '0;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    assign periodEnd = state_q.wrap;
    assign pwmLevel  = state_q.level;

endmodule : pfs_period_gen

/* File: design/pfs_top.sv */
// PWM frequency synthesizer top: request capture, divider, output pair
`timescale 1ns/1ps
module pfs_top
    import pfs_pkg::*;
#(
    parameter pfs_res_type RES_TYPE = PFS_RES_ONE,
    parameter bit          FAST_FITTED = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    input  wire pfs_req_type req,
    output logic [1:0]       pwmOutputPair,
    output logic             pwmStandardOut,
    output logic             periodStrobe,
    output logic [15:0]      actualFreqHz,
    output logic             reqClamped
);

    // Reference selection is fixed at build time
    localparam logic [16:0] REF_HZ  = (RES_TYPE == PFS_RES_ONE) ?
        17'(REF_ONE_HZ) : 17'(REF_TWO_HZ);
    localparam logic [11:0] REF_CYC = (RES_TYPE == PFS_RES_ONE) ?
        12'(REF_ONE_CYC) : 12'(REF_TWO_CYC);
    localparam logic [15:0] FMAX    = FAST_FITTED ? 16'(FREQ_MAX_FAST) : 16'(FREQ_MAX_SLOW);

    typedef enum logic [1:0] {DIV_IDLE, DIV_RUN, DIV_DONE} pfs_div_type;

    typedef struct packed {
        logic [15:0] freq;
        logic [9:0]  duty;
        logic        modeOn;
        logic        clamped;
        pfs_div_type divState;
        logic [4:0]  divBit;
        logic [17:0] num;
        logic [17:0] rem;
        logic [17:0] quo;
        pfs_cfg_type cfg;
        logic [11:0] refCnt;
        logic        refTick;
        logic [1:0]  pair;
        logic        standard;
        logic        strobe;
        logic [15:0] actual;
        logic [16:0] outNum;
    } pfs_state_type;

    pfs_state_type state_q, state_d;
    logic          genEnd;
    logic          genLevel;
    logic [15:0]   freqLim;
    logic [27:0]   highProd;

    pfs_period_gen u_gen (
        .mclk      (mclk),
        .reset     (reset),
        .clkEn     (clkEn),
        .refTick   (state_q.refTick),
        .cfg       (state_q.cfg),
        .periodEnd (genEnd),
        .pwmLevel  (genLevel)
    );

    // Clamp the request into the range the fitted hardware supports
    always_comb begin
        freqLim = req.freqHz;
        if (req.freqHz > FMAX) begin
            freqLim = FMAX;
        end else if (req.freqHz < 16'(FREQ_MIN_HZ)) begin
            freqLim = 16'(FREQ_MIN_HZ);
        end
    end

    assign highProd = 28'(state_q.quo[13:0]) * 28'(state_q.duty);

    // Capture, restoring divider, reference ticks and output staging
    always_comb begin
        state_d         = state_q;
        state_d.refTick = 1'b0;
        state_d.strobe  = genEnd;
        if (state_q.refCnt == REF_CYC - 12'h001) begin
            state_d.refCnt  = 12'h000;
            state_d.refTick = 1'b1;
        end else begin
            state_d.refCnt = state_q.refCnt + 12'h001;
        end
        if (req.dutyValid) begin
            state_d.duty = (req.dutyPermil > 10'(DUTY_FULL)) ? 10'(DUTY_FULL) : req.dutyPermil;
        end
        if (req.modeValid) begin
            state_d.modeOn = req.modeOn;
        end
        unique case (state_q.divState)
            DIV_IDLE: begin
            end
            DIV_RUN: begin
                // Restoring divide of (ref + f/2) by f gives rounded scalar
                state_d.rem = {state_q.rem[16:0], state_q.num[17]};
                state_d.num = {state_q.num[16:0], 1'b0};
                state_d.quo = {state_q.quo[16:0], 1'b0};
                if ({state_q.rem[16:0], state_q.num[17]} >= 18'(state_q.freq)) begin
                    state_d.rem = {state_q.rem[16:0], state_q.num[17]} - 18'(state_q.freq);
                    state_d.quo = {state_q.quo[16:0], 1'b1};
                end
                state_d.divBit = state_q.divBit - 5'h01;
                if (state_q.divBit == 5'h00) begin
                    state_d.divState = DIV_DONE;
                end
            end
            DIV_DONE: begin
                // Actual output is ref over scalar; staged for next wrap
                state_d.cfg.enable    = state_q.modeOn && (state_q.quo != 18'h0);
                state_d.cfg.scalar    = state_q.quo[13:0];
                state_d.cfg.highTicks = 14'(highProd / 28'(DUTY_FULL));
                state_d.actual        = (state_q.quo == 18'h0) ? 16'h0000 :
                    16'(state_q.outNum / 17'(state_q.quo[13:0]));
                state_d.divState      = DIV_IDLE;
            end
            default: state_d.divState = DIV_IDLE;
        endcase
        // Restage duty or mode; a running divide is never cut short,
        // its own DONE step picks up the new values
        if ((req.dutyValid || req.modeValid) && state_d.divState != DIV_RUN) begin
            state_d.divState = DIV_DONE;
        end
        if (req.freqValid) begin
            state_d.freq     = freqLim;
            state_d.clamped  = (freqLim != req.freqHz);
            state_d.num      = 18'(REF_HZ) + 18'(freqLim >> 1);
            state_d.outNum   = REF_HZ;
            state_d.rem      = 18'h0;
            state_d.quo      = 18'h0;
            state_d.divBit   = 5'h11;
            state_d.divState = DIV_RUN;
        end
        // Fast option feeds the buffered pair; otherwise the standard output
        state_d.pair     = FAST_FITTED ? {genLevel, genLevel} : 2'b00;
        state_d.standard = FAST_FITTED ? 1'b0 : genLevel;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q        <= '0;
            state_q.freq   <= FREQ_RESET;
            state_q.duty   <= DUTY_RESET;
            state_q.divState <= DIV_IDLE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    assign pwmOutputPair  = state_q.pair;
    assign pwmStandardOut = state_q.standard;
    assign periodStrobe   = state_q.strobe;
    assign actualFreqHz   = state_q.actual;
    assign reqClamped     = state_q.clamped;

    // Checks
    a_cap_freq: assert property (@(posedge mclk) disable iff (reset)
        state_q.freq <= FMAX) else $error("frequency above cap");
    a_min_freq: assert property (@(posedge mclk) disable iff (reset)
        clkEn && req.freqValid |=> state_q.freq >= 16'(FREQ_MIN_HZ))
        else $error("frequency below floor");
    a_div_len: assert property (@(posedge mclk) disable iff (reset)
        clkEn && req.freqValid && !req.dutyValid && !req.modeValid
        ##1 (clkEn && !req.freqValid && !req.dutyValid && !req.modeValid)[*8]
        |-> state_q.divState == DIV_RUN) else $error("divider ended early");
    a_ref_tick: assert property (@(posedge mclk) disable iff (reset)
        state_q.refTick |-> state_q.refCnt == 12'h000) else $error("ref tick misplaced");
    a_scalar_ok: assert property (@(posedge mclk) disable iff (reset)
        clkEn && state_q.divState == DIV_DONE && state_q.quo != 18'h0
        |=> state_q.cfg.scalar == $past(state_q.quo[13:0])) else $error("scalar not staged");
    a_duty_fit: assert property (@(posedge mclk) disable iff (reset)
        state_q.cfg.highTicks <= state_q.cfg.scalar) else $error("high beyond period");
    a_pair_same: assert property (@(posedge mclk) disable iff (reset)
        pwmOutputPair[0] == pwmOutputPair[1]) else $error("pair split");
    a_slow_only: assert property (@(posedge mclk) disable iff (reset)
        !FAST_FITTED |-> pwmOutputPair == 2'b00) else $error("pair driven unfitted");
    a_std_zero: assert property (@(posedge mclk) disable iff (reset)
        FAST_FITTED |-> !pwmStandardOut) else $error("standard driven when fitted");

    // Divider is not cut short by a duty or mode strobe
    a_div_restage: assert property (@(posedge mclk) disable iff (reset)
        clkEn && state_q.divState == DIV_RUN && state_q.divBit != 5'h00 && !req.freqValid
        && (req.dutyValid || req.modeValid) |=> state_q.divState == DIV_RUN)
        else $error("divide cut short");

    // Request and result ranges
    a_clamp_flag: assert property (@(posedge mclk) disable iff (reset)
        clkEn && req.freqValid && req.freqHz > FMAX |=> reqClamped)
        else $error("clamp not flagged");
    a_actual_cap: assert property (@(posedge mclk) disable iff (reset)
        actualFreqHz <= FMAX) else $error("actual above cap");
    a_duty_cap: assert property (@(posedge mclk) disable iff (reset)
        state_q.duty <= 10'(DUTY_FULL)) else $error("duty above full");
    a_freq_floor: assert property (@(posedge mclk) disable iff (reset)
        state_q.freq == 16'h0000 || state_q.freq >= 16'(FREQ_MIN_HZ))
        else $error("held frequency below floor");

    // Staging and reference timing
    a_mode_off: assert property (@(posedge mclk) disable iff (reset)
        clkEn && state_q.divState == DIV_DONE && !state_q.modeOn |=> !state_q.cfg.enable)
        else $error("enabled while mode off");
    a_cfg_quiet: assert property (@(posedge mclk) disable iff (reset)
        clkEn && state_q.divState == DIV_IDLE && !req.freqValid && !req.dutyValid
        && !req.modeValid |=> $stable(state_q.cfg)) else $error("cfg changed unasked");
    a_tick_range: assert property (@(posedge mclk) disable iff (reset)
        state_q.refCnt < REF_CYC) else $error("reference count overrun");
    a_strobe_once: assert property (@(posedge mclk) disable iff (reset)
        clkEn && periodStrobe |=> !periodStrobe) else $error("strobe too long");

    c_freq_req: cover property (@(posedge mclk) clkEn && req.freqValid);
    c_wrap: cover property (@(posedge mclk) periodStrobe);
    c_out_high: cover property (@(posedge mclk) pwmOutputPair == 2'b11);
    c_clamped: cover property (@(posedge mclk) reqClamped);

endmodule : pfs_top

/* File: testbench/pfs_load_model.sv */
// Load model that times the buffered output pair in mclk cycles
`timescale 1ns/1ps
module pfs_load_model (
    input  wire logic [1:0] pinPair,
    input  wire logic       mclk,
    output int              periodCyc,
    output int              highCyc,
    output logic            pairSplit
);
    int   count;
    logic lastLvl;

    // Start unsplit; the first period read is partial and must be skipped
    initial begin
        count = 0;
        lastLvl = 1'b0;
        periodCyc = 0;
        highCyc = 0;
        pairSplit = 1'b0;
    end

    // Edge timing of pin zero; any disagreement between the pins is latched
    always @(posedge mclk) begin
        count <= count + 1;
        lastLvl <= pinPair[0];
        if (pinPair[0] !== pinPair[1]) begin
            pairSplit <= 1'b1;
        end
        if (pinPair[0] === 1'b1 && lastLvl === 1'b0) begin
            periodCyc <= count;
            count <= 1;
        end
        if (pinPair[0] === 1'b0 && lastLvl === 1'b1) begin
            highCyc <= count;
        end
    end
endmodule : pfs_load_model

/* File: testbench/pwm_frequency_synthesizer_bench.sv */
// Self-checking bench: three variants of the synthesizer and two loads
`timescale 1ns/1ps
module pwm_frequency_synthesizer_bench import pfs_pkg::*; ;
    logic        mclk, reset, clkEn;
    pfs_req_type req;
    logic [1:0]  pairA, pairB, pairC;
    logic        stdA, stdC, strA, clA, clB, clC;
    logic [15:0] fA, fB, fC;
    int          perA, hiA, perB, hiB, fails, comparisons, cycles;
    logic        splitA, splitB;

    // Type one fast, type two fast, type one without the fast option
    pfs_top #(.RES_TYPE(PFS_RES_ONE), .FAST_FITTED(1'b1)) u_dut (.mclk(mclk), .reset(reset),
        .clkEn(clkEn), .req(req), .pwmOutputPair(pairA), .pwmStandardOut(stdA),
        .periodStrobe(strA), .actualFreqHz(fA), .reqClamped(clA));
    pfs_top #(.RES_TYPE(PFS_RES_TWO), .FAST_FITTED(1'b1)) u_dut_two (.mclk(mclk),
        .reset(reset), .clkEn(clkEn), .req(req), .pwmOutputPair(pairB), .pwmStandardOut(),
        .periodStrobe(), .actualFreqHz(fB), .reqClamped(clB));
    pfs_top #(.RES_TYPE(PFS_RES_ONE), .FAST_FITTED(1'b0)) u_dut_slow (.mclk(mclk),
        .reset(reset), .clkEn(clkEn), .req(req), .pwmOutputPair(pairC), .pwmStandardOut(stdC),
        .periodStrobe(), .actualFreqHz(fC), .reqClamped(clC));
    pfs_load_model u_load_a (.pinPair(pairA), .mclk(mclk), .periodCyc(perA), .highCyc(hiA),
        .pairSplit(splitA));
    pfs_load_model u_load_b (.pinPair(pairB), .mclk(mclk), .periodCyc(perB), .highCyc(hiB),
        .pairSplit(splitB));

    // Expected rate: reference over the rounded scalar
    function automatic int fa(input int r, input int f);
        return r / ((r + f / 2) / f);
    endfunction : fa

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One strobe cycle, then room for the 19-cycle divide and the clamp flag
    task automatic send(input logic [15:0] f, input logic [9:0] d, input logic [2:0] v);
        @(posedge mclk);
        req <= '{v[2], f, v[1], d, v[0], v[0]};
        @(posedge mclk);
        req <= '0;
        repeat (22) @(posedge mclk);
        #1;
    endtask : send

    task automatic wait_strobes(input int n);
        int k;
        k = 0;
        while (k < n) begin
            @(posedge mclk);
            if (strA === 1'b1) k++;
        end
        #1;
    endtask : wait_strobes

    task automatic report_and_stop;
        $display("counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic t_divider;
        send(16'h1b58, 10'h0, 3'b100);
        chk(fA, fa(REF_ONE_HZ, 7000));
        chk(fB, fa(REF_TWO_HZ, 7000));
        chk(fC, FREQ_MAX_SLOW);
        chk(clC, 1'b1);
        chk(clA, 1'b0);
        send(16'h00ea, 10'h0, 3'b100);
        chk(fA, 234);
        send(16'h0137, 10'h0, 3'b100);
        chk(fB, 311);
        $display("test divider done");
    endtask : t_divider

    task automatic t_clamp;
        send(16'h7530, 10'h0, 3'b100);
        chk(fA, FREQ_MAX_FAST);
        chk(clA, 1'b1);
        send(16'h0005, 10'h0, 3'b100);
        chk(fA, FREQ_MIN_HZ);
        chk(clC, 1'b1);
        $display("test clamp done");
    endtask : t_clamp

    // Mode last, so the generator starts on a whole period
    task automatic t_wave;
        send(16'h4e20, 10'h1f4, 3'b110);
        send(16'h0, 10'h0, 3'b001);
        wait_strobes(3);
        chk(perA, 3 * REF_ONE_CYC);
        chk(hiA, REF_ONE_CYC);
        chk(perB, 4 * REF_TWO_CYC);
        chk(hiB, 2 * REF_TWO_CYC);
        chk(stdA, 1'b0);
        chk(pairC, 2'b00);
        chk(stdC, 1'b1);
        chk({splitA, splitB}, 2'b00);
        send(16'h2710, 10'h0, 3'b100);
        wait_strobes(3);
        chk(perA, 6 * REF_ONE_CYC);
        chk(hiA, 3 * REF_ONE_CYC);
        $display("test waveform done");
    endtask : t_wave

    // Clock and a cycle ceiling well above the expected 50k cycles
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            fails++;
            report_and_stop;
        end
    end

    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        clkEn = 1'b1;
        req = '0;
        fails = 0;
        comparisons = 0;
        cycles = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        chk({pairA, fA, clA}, 19'h0);
        t_divider;
        t_clamp;
        t_wave;
        report_and_stop;
    end
endmodule : pwm_frequency_synthesizer_bench
